// File: design/ebtc_pkg.sv
// constants and types shared by the external bus timing control block
package ebtc_pkg;
   // bus timing control register layout
   localparam logic [31:0] BCR_RESET = 32'hFFFFFFFF;
   localparam int PARITY_LSB = 28;
   localparam int S3_ACC_LSB = 24;
   localparam int S3_HOLD_MSB_BIT = 23;
   localparam int S2_ACC_LSB = 20;
   localparam int S1_ACC_LSB = 18;
   localparam int S0_ACC_LSB = 16;
   localparam int S1_HOLD_BIT = 15;
   localparam int S2_SETUP_BIT = 14;
   localparam int REFRESH_LSB = 12;
   localparam int PRECHARGE_LSB = 10;
   localparam int ROW_COL_LSB = 8;
   localparam int PAGE_LSB = 4;
   localparam int S3_HOLD_LSB = 2;
   localparam int S2_HOLD_LSB = 0;
   // i/o address timing fields
   localparam int IO_DS_BIT = 10;
   localparam int IO_HOLD_LSB = 8;
   localparam int IO_SETUP_LSB = 6;
   localparam int IO_ACC_LSB = 3;
   // address space decode
   localparam int SPACE_LSB = 30;
   // refresh counter reloads (period in clock cycles minus one), off code and refresh length
   localparam logic [9:0] REF_PERIOD_512 = 10'h1FF;
   localparam logic [9:0] REF_PERIOD_256 = 10'h0FF;
   localparam logic [9:0] REF_PERIOD_128 = 10'h07F;
   localparam logic [1:0] REF_OFF = 2'h3;
   localparam logic [4:0] REF_LEN = 5'h04;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_SETUP = 5'h02,
      ST_ACCESS = 5'h04,
      ST_HOLD = 5'h08,
      ST_REFRESH = 5'h10
   } ebtc_state_t;
endpackage

// File: design/ebtc_refresh_timer.sv
// refresh interval timer raising a sticky refresh request
`timescale 1ns/1ns
module ebtc_refresh_timer (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // control
   input wire logic [1:0] rate_code,
   input wire logic ack,
   // request
   output logic due
);
   typedef struct packed {
      logic [9:0] cnt;
      logic due;
   } ebtc_tmr_t;

   ebtc_tmr_t s_r, s_nxt;

   function automatic logic [9:0] ebtc_period(input logic [1:0] code);
      unique case (code)
         2'h0: ebtc_period = ebtc_pkg::REF_PERIOD_512;
         2'h1: ebtc_period = ebtc_pkg::REF_PERIOD_256;
         default: ebtc_period = ebtc_pkg::REF_PERIOD_128;
      endcase
   endfunction

   always_comb begin
      s_nxt = s_r;
      if (rate_code == ebtc_pkg::REF_OFF) begin
         s_nxt.cnt = ebtc_period(2'h2);
         s_nxt.due = 1'b0;
      end else begin
         if (ack) begin
            s_nxt.due = 1'b0;
         end
         if (s_r.cnt == 10'h000) begin
            s_nxt.cnt = ebtc_period(rate_code);
            s_nxt.due = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt - 10'h001;
         end
         if (s_r.cnt > ebtc_period(rate_code)) begin
            s_nxt.cnt = ebtc_period(rate_code);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_r <= '{cnt: ebtc_pkg::REF_PERIOD_128, due: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign due = s_r.due;

   refresh_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      rate_code == ebtc_pkg::REF_OFF |=> !due)
      else $error("refresh requested while refresh is off");
   refresh_rise_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(due) |-> $past(s_r.cnt) == 10'h000)
      else $error("refresh request before interval elapsed");
endmodule // ebtc_refresh_timer

// File: design/ebtc_top.sv
// external bus timing control: timing register, access sequencer, refresh
// What this block does
// - i/o timing taken from address bits 10..3
// - i/o strobe low after first access cycle, or in a lone cycle
// - setup cycles delay the i/o strobe
// - hold cycles follow access, delay next access
// - address bit 10 selects data strobe mode
// - data strobe write pulses read strobe only
// - timing register write-only, resets all ones
// - bits 31..28 disable parity per space
// - space three access is code plus one
// - space two access is code plus one
// - space one access is code plus one
// - space zero access sets column strobe cycles
// - bit 15 gives space one hold cycle
// - bit 14 gives space two setup cycle
// - refresh every 512/256/128 cycles or off
// - dram precharge is code plus one cycles
// - non-dram space zero hold equals code
// - row to column delay code plus one
// - bit 23 is space three hold msb
// - space three hold is three-bit code
// - bits 1..0 give space two hold
// - bits 6..4 select dram page size
`timescale 1ns/1ns
module ebtc_top (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // global register twenty write port
   input wire logic global_reg_twenty_wr,
   input wire logic [31:0] global_reg_twenty_wdata,
   // memory space zero type, 1 = non-dram
   input wire logic space0_non_dram,
   // access request
   input wire logic req_valid,
   input wire logic req_io,
   input wire logic req_write,
   input wire logic [31:0] req_addr,
   output logic req_ready,
   output logic req_done,
   // bus strobes
   output logic io_read_strobe_n,
   output logic io_write_strobe_n,
   output logic write_enable_n,
   output logic output_enable_n,
   output logic mem_write_strobe_n,
   output logic column_strobe_n,
   output logic row_strobe_n,
   // configuration for the rest of the bus unit
   output logic [3:0] space_parity_off,
   output logic [2:0] dram_page_size,
   output logic refresh_active
);
   typedef struct packed {
      ebtc_pkg::ebtc_state_t fsm;
      logic [4:0] cnt;
      logic [4:0] setup_len;
      logic [4:0] acc_len;
      logic [2:0] hold_len;
      logic is_io;
      logic is_write;
      logic ds_mode;
      logic dram;
      logic [1:0] space;
      logic [1:0] cas_code;
      logic [1:0] pre_code;
      logic [31:0] bus_timing_control;
      logic ready;
      logic done;
      logic io_rd_n;
      logic io_wr_n;
      logic we_n;
      logic oe_n;
      logic mw_n;
      logic cas_n;
      logic ras_n;
      logic ref_act;
   } ebtc_regs_t;

   ebtc_regs_t s_r, s_nxt;
   logic ref_due;
   logic ref_ack;
   logic take;

   // column strobe cycle within a dram access
   function automatic logic ebtc_cas_on(input logic [1:0] code, input logic [4:0] k);
      unique case (code)
         2'h0: ebtc_cas_on = (k == 5'h01);
         2'h1: ebtc_cas_on = (k == 5'h02);
         2'h2: ebtc_cas_on = (k == 5'h02) || (k == 5'h03);
         default: ebtc_cas_on = (k == 5'h03) || (k == 5'h04);
      endcase
   endfunction

   // strobe low after the first access cycle, or in a lone cycle
   function automatic logic ebtc_strobe_on(input logic [4:0] len, input logic [4:0] k);
      ebtc_strobe_on = (len == 5'h01) || (k >= 5'h02);
   endfunction

   ebtc_refresh_timer u_refresh (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .rate_code(s_r.bus_timing_control[ebtc_pkg::REFRESH_LSB +: 2]),
      .ack(ref_ack),
      .due(ref_due)
   );

   assign take = req_valid && s_r.ready && (s_r.fsm == ebtc_pkg::ST_IDLE);
   assign ref_ack = (s_r.fsm == ebtc_pkg::ST_IDLE) && !take && ref_due;

   always_comb begin
      logic [31:0] b;
      logic [1:0] sp;
      b = s_r.bus_timing_control;
      sp = req_addr[ebtc_pkg::SPACE_LSB +: 2];
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (global_reg_twenty_wr) begin
         s_nxt.bus_timing_control = global_reg_twenty_wdata;
      end
      unique case (s_r.fsm)
         ebtc_pkg::ST_IDLE: begin
            if (take) begin
               s_nxt.is_io = req_io;
               s_nxt.is_write = req_write;
               s_nxt.space = sp;
               s_nxt.ds_mode = 1'b0;
               s_nxt.dram = 1'b0;
               s_nxt.cas_code = b[ebtc_pkg::S0_ACC_LSB +: 2];
               s_nxt.pre_code = b[ebtc_pkg::PRECHARGE_LSB +: 2];
               s_nxt.setup_len = 5'h00;
               s_nxt.hold_len = 3'h0;
               if (req_io) begin
                  s_nxt.ds_mode = req_addr[ebtc_pkg::IO_DS_BIT];
                  s_nxt.acc_len = {2'h0, req_addr[ebtc_pkg::IO_ACC_LSB +: 3]} + 5'h01;
                  s_nxt.setup_len = {3'h0, req_addr[ebtc_pkg::IO_SETUP_LSB +: 2]};
                  s_nxt.hold_len = {1'b0, req_addr[ebtc_pkg::IO_HOLD_LSB +: 2]};
               end else begin
                  unique case (sp)
                     2'h3: begin
                        s_nxt.acc_len = {1'b0, b[ebtc_pkg::S3_ACC_LSB +: 4]} + 5'h01;
                        s_nxt.hold_len = {b[ebtc_pkg::S3_HOLD_MSB_BIT],
                           b[ebtc_pkg::S3_HOLD_LSB +: 2]};
                     end
                     2'h2: begin
                        s_nxt.acc_len = {2'h0, b[ebtc_pkg::S2_ACC_LSB +: 3]} + 5'h01;
                        s_nxt.setup_len = {4'h0, b[ebtc_pkg::S2_SETUP_BIT]};
                        s_nxt.hold_len = {1'b0, b[ebtc_pkg::S2_HOLD_LSB +: 2]};
                     end
                     2'h1: begin
                        s_nxt.acc_len = {3'h0, b[ebtc_pkg::S1_ACC_LSB +: 2]} + 5'h01;
                        s_nxt.hold_len = {2'h0, b[ebtc_pkg::S1_HOLD_BIT]};
                     end
                     default: begin
                        s_nxt.acc_len = {3'h0, b[ebtc_pkg::S0_ACC_LSB +: 2]} + 5'h01;
                        s_nxt.dram = !space0_non_dram;
                        if (space0_non_dram) begin
                           s_nxt.hold_len = {1'b0, b[ebtc_pkg::PRECHARGE_LSB +: 2]};
                        end else begin
                           // row phase: precharge then row to column delay
                           s_nxt.setup_len = {3'h0, b[ebtc_pkg::PRECHARGE_LSB +: 2]}
                              + {3'h0, b[ebtc_pkg::ROW_COL_LSB +: 2]} + 5'h02;
                        end
                     end
                  endcase
               end
               s_nxt.cnt = 5'h01;
               if (s_nxt.setup_len != 5'h00) begin
                  s_nxt.fsm = ebtc_pkg::ST_SETUP;
               end else begin
                  s_nxt.fsm = ebtc_pkg::ST_ACCESS;
               end
            end else if (ref_due) begin
               s_nxt.fsm = ebtc_pkg::ST_REFRESH;
               s_nxt.cnt = 5'h01;
            end
         end
         ebtc_pkg::ST_SETUP: begin
            if (s_r.cnt == s_r.setup_len) begin
               s_nxt.fsm = ebtc_pkg::ST_ACCESS;
               s_nxt.cnt = 5'h01;
            end else begin
               s_nxt.cnt = s_r.cnt + 5'h01;
            end
         end
         ebtc_pkg::ST_ACCESS: begin
            if (s_r.cnt == s_r.acc_len) begin
               s_nxt.cnt = 5'h01;
               if (s_r.hold_len != 3'h0) begin
                  s_nxt.fsm = ebtc_pkg::ST_HOLD;
               end else begin
                  s_nxt.fsm = ebtc_pkg::ST_IDLE;
                  s_nxt.done = 1'b1;
               end
            end else begin
               s_nxt.cnt = s_r.cnt + 5'h01;
            end
         end
         ebtc_pkg::ST_HOLD: begin
            if (s_r.cnt == {2'h0, s_r.hold_len}) begin
               s_nxt.fsm = ebtc_pkg::ST_IDLE;
               s_nxt.done = 1'b1;
            end else begin
               s_nxt.cnt = s_r.cnt + 5'h01;
            end
         end
         ebtc_pkg::ST_REFRESH: begin
            if (s_r.cnt == ebtc_pkg::REF_LEN) begin
               s_nxt.fsm = ebtc_pkg::ST_IDLE;
            end else begin
               s_nxt.cnt = s_r.cnt + 5'h01;
            end
         end
      endcase
      // pin levels follow the next state so the pins are plain flops
      s_nxt.ready = (s_nxt.fsm == ebtc_pkg::ST_IDLE);
      s_nxt.ref_act = (s_nxt.fsm == ebtc_pkg::ST_REFRESH);
      s_nxt.io_rd_n = 1'b1;
      s_nxt.io_wr_n = 1'b1;
      s_nxt.oe_n = 1'b1;
      s_nxt.mw_n = 1'b1;
      s_nxt.cas_n = 1'b1;
      s_nxt.ras_n = 1'b1;
      s_nxt.we_n = !(s_nxt.is_write && (s_nxt.fsm == ebtc_pkg::ST_SETUP
         || s_nxt.fsm == ebtc_pkg::ST_ACCESS || s_nxt.fsm == ebtc_pkg::ST_HOLD));
      if (s_nxt.fsm == ebtc_pkg::ST_ACCESS) begin
         if (s_nxt.is_io) begin
            if (ebtc_strobe_on(s_nxt.acc_len, s_nxt.cnt)) begin
               if (!s_nxt.is_write || s_nxt.ds_mode) begin
                  s_nxt.io_rd_n = 1'b0;
               end else begin
                  s_nxt.io_wr_n = 1'b0;
               end
            end
         end else if (s_nxt.dram) begin
            s_nxt.ras_n = 1'b0;
            s_nxt.cas_n = !ebtc_cas_on(s_nxt.cas_code, s_nxt.cnt);
         end else if (ebtc_strobe_on(s_nxt.acc_len, s_nxt.cnt)) begin
            s_nxt.oe_n = s_nxt.is_write;
            s_nxt.mw_n = !s_nxt.is_write;
         end
      end
      if (s_nxt.fsm == ebtc_pkg::ST_SETUP && s_nxt.dram
         && s_nxt.cnt > {3'h0, s_nxt.pre_code} + 5'h01) begin
         s_nxt.ras_n = 1'b0;
      end
      if (s_nxt.fsm == ebtc_pkg::ST_REFRESH) begin
         // column strobe leads, row strobe follows from the second cycle
         s_nxt.cas_n = 1'b0;
         s_nxt.ras_n = (s_nxt.cnt == 5'h01);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_r <= '{fsm: ebtc_pkg::ST_IDLE, cnt: 5'h00, setup_len: 5'h00, acc_len: 5'h01,
            hold_len: 3'h0, is_io: 1'b0, is_write: 1'b0, ds_mode: 1'b0, dram: 1'b0,
            space: 2'h0, cas_code: 2'h0, pre_code: 2'h0, bus_timing_control: ebtc_pkg::BCR_RESET, ready: 1'b1,
            done: 1'b0, io_rd_n: 1'b1, io_wr_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
            mw_n: 1'b1, cas_n: 1'b1, ras_n: 1'b1, ref_act: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign req_ready = s_r.ready;
   assign req_done = s_r.done;
   assign io_read_strobe_n = s_r.io_rd_n;
   assign io_write_strobe_n = s_r.io_wr_n;
   assign write_enable_n = s_r.we_n;
   assign output_enable_n = s_r.oe_n;
   assign mem_write_strobe_n = s_r.mw_n;
   assign column_strobe_n = s_r.cas_n;
   assign row_strobe_n = s_r.ras_n;
   assign space_parity_off = s_r.bus_timing_control[ebtc_pkg::PARITY_LSB +: 4];
   assign dram_page_size = s_r.bus_timing_control[ebtc_pkg::PAGE_LSB +: 3];
   assign refresh_active = s_r.ref_act;

   // helper: access cycles counted independently of the sequencer
   logic [4:0] acc_seen_r;
   always_ff @(posedge core_clk) begin
      if (!rst_n || s_r.fsm != ebtc_pkg::ST_ACCESS) begin
         acc_seen_r <= 5'h00;
      end else begin
         acc_seen_r <= acc_seen_r + 5'h01;
      end
   end

   reg_reset_a: assert property (@(posedge core_clk)
      !rst_n |=> space_parity_off == 4'hF && dram_page_size == 3'h7)
      else $error("timing register not all ones after reset");
   parity_map_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      global_reg_twenty_wr |=> space_parity_off == $past(global_reg_twenty_wdata[31:28]))
      else $error("parity disable bits not taken from 31..28");
   ds_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_r.is_io && s_r.ds_mode && s_r.is_write |-> io_write_strobe_n)
      else $error("write strobe active in data strobe mode");
   io_first_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(s_r.fsm == ebtc_pkg::ST_ACCESS) && s_r.is_io && s_r.acc_len > 5'h01
      |-> io_read_strobe_n && io_write_strobe_n ##1 !(io_read_strobe_n && io_write_strobe_n))
      else $error("i/o strobe not low from second access cycle");
   setup_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_r.fsm == ebtc_pkg::ST_SETUP |-> io_read_strobe_n && io_write_strobe_n
      && output_enable_n && mem_write_strobe_n)
      else $error("strobe active during setup");
   hold_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_r.fsm == ebtc_pkg::ST_HOLD |-> !req_ready && io_read_strobe_n && io_write_strobe_n)
      else $error("hold cycle not quiet or not blocking");
   access_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_r.fsm == ebtc_pkg::ST_ACCESS && s_nxt.fsm != ebtc_pkg::ST_ACCESS && !s_r.is_io
      && !s_r.dram |-> acc_seen_r + 5'h01 == ({1'b0,
      (s_r.space == 2'h3) ? s_r.bus_timing_control[27:24] : (s_r.space == 2'h2) ? {1'b0, s_r.bus_timing_control[22:20]} :
      (s_r.space == 2'h1) ? {2'h0, s_r.bus_timing_control[19:18]} : {2'h0, s_r.bus_timing_control[17:16]}} + 5'h01))
      else $error("memory access length differs from code plus one");
   s3_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      take && !req_io && req_addr[31:30] == 2'h3
      |=> s_r.hold_len == $past({s_r.bus_timing_control[23], s_r.bus_timing_control[3:2]}))
      else $error("space three hold code wrong");
   cas_one_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(s_r.fsm == ebtc_pkg::ST_ACCESS) && s_r.dram && s_r.cas_code == 2'h3
      |-> column_strobe_n ##1 column_strobe_n ##1 !column_strobe_n ##1 !column_strobe_n)
      else $error("column strobe not in cycles three and four");
   refresh_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(refresh_active) |-> $past(s_r.fsm) == ebtc_pkg::ST_IDLE)
      else $error("refresh cut into an access");

   io_rd_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      take && req_io && !req_write ##[1:20] req_done);
   io_ds_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      s_r.is_io && s_r.ds_mode && s_r.is_write && !io_read_strobe_n);
   hold_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      s_r.fsm == ebtc_pkg::ST_HOLD);
   refresh_c: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(refresh_active));
endmodule // ebtc_top

// File: verif/ebtc_bus_device.sv
// far side bus device model that counts strobe low cycles per access
`timescale 1ns/1ns
module ebtc_bus_device (
   // clock and control
   input wire logic core_clk,
   input wire logic clr,
   // strobes seen on the bus, active low
   input wire logic [6:0] strobe_n,
   // low cycles seen per strobe since last clear
   output logic [6:0][4:0] low_cnt
);
   always @(posedge core_clk) begin
      for (int i = 0; i < 7; i++) begin
         if (clr) begin
            low_cnt[i] <= 5'h00;
         end else if (strobe_n[i] === 1'b0) begin
            low_cnt[i] <= low_cnt[i] + 5'h01;
         end
      end
   end
endmodule // ebtc_bus_device

// File: verif/tb.sv
// self-checking testbench of the external bus timing control block
`timescale 1ns/1ns
module tb;
   logic core_clk, rst_n, wr, nd, rv, rio, rwr, clr;
   logic [31:0] wd, ra, bus_timing_control, r, d, a;
   logic req_ready, req_done, refresh_active;
   logic [6:0] stb_n;
   logic [6:0][4:0] low_cnt;
   logic [3:0] space_parity_off;
   logic [2:0] dram_page_size;
   int compares, miscompares;
   int cyc = 0, rf_n = 0, rf_len = 0, rf_prev = 0, rf_last = 0;

   ebtc_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .global_reg_twenty_wr(wr),
      .global_reg_twenty_wdata(wd), .space0_non_dram(nd), .req_valid(rv), .req_io(rio),
      .req_write(rwr), .req_addr(ra), .req_ready(req_ready), .req_done(req_done),
      .io_read_strobe_n(stb_n[0]), .io_write_strobe_n(stb_n[1]),
      .output_enable_n(stb_n[2]), .mem_write_strobe_n(stb_n[3]),
      .column_strobe_n(stb_n[4]), .row_strobe_n(stb_n[5]), .write_enable_n(stb_n[6]),
      .space_parity_off(space_parity_off), .dram_page_size(dram_page_size),
      .refresh_active(refresh_active));
   ebtc_bus_device i_dev (.core_clk(core_clk), .clr(clr), .strobe_n(stb_n),
      .low_cnt(low_cnt));

   initial core_clk = 1'b0;
   always #2 core_clk = ~core_clk;

   // refresh start times and burst length
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      rf_n <= (refresh_active === 1'b1) ? rf_n + 1 : 0;
      if (refresh_active === 1'b1 && rf_n == 0) begin
         rf_prev <= rf_last;
         rf_last <= cyc;
      end
      if (refresh_active !== 1'b1 && rf_n != 0) rf_len <= rf_n;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic void calc(input logic io, w, n, input logic [31:0] a, b,
      output int len, output logic [6:0][4:0] ec);
      int s, ac, h, st;
      s = 0;
      h = 0;
      ec = '0;
      if (io) begin
         ac = a[5:3] + 1;
         s = a[7:6];
         h = a[9:8];
      end else case (a[31:30])
         2'h3: begin ac = b[27:24] + 1; h = {b[23], b[3:2]}; end
         2'h2: begin ac = b[22:20] + 1; s = b[14]; h = b[1:0]; end
         2'h1: begin ac = b[19:18] + 1; h = b[15]; end
         default: begin
            ac = b[17:16] + 1;
            if (n) h = b[11:10];
            else s = b[11:10] + b[9:8] + 2;
         end
      endcase
      st = (ac == 1) ? 1 : ac - 1;
      len = s + ac + h + 1;
      if (w) ec[6] = 5'(s + ac + h);
      if (io) ec[(w && !a[10]) ? 1 : 0] = 5'(st);
      else if (a[31:30] == 2'h0 && !n) begin
         ec[4] = b[17] ? 5'h02 : 5'h01;
         ec[5] = 5'(b[9:8] + 1 + ac);
      end else ec[w ? 3 : 2] = 5'(st);
   endfunction

   task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   task automatic set_bcr(input logic [31:0] v);
      @(posedge core_clk);
      wr <= 1'b1;
      wd <= v;
      bus_timing_control = v;
      @(posedge core_clk);
      wr <= 1'b0;
      @(negedge core_clk);
      check("parity_off", 64'(v[31:28]), 64'(space_parity_off));
      check("page_size", 64'(v[6:4]), 64'(dram_page_size));
   endtask

   task automatic run(input logic io, w, n, input logic [31:0] a);
      int len, m, k;
      logic [6:0][4:0] ec;
      logic rdy;
      calc(io, w, n, a, bus_timing_control, len, ec);
      @(posedge core_clk);
      rv <= 1'b1;
      rio <= io;
      rwr <= w;
      nd <= n;
      ra <= a;
      clr <= 1'b1;
      k = 0;
      do begin
         @(negedge core_clk);
         rdy = req_ready;
         @(posedge core_clk);
         k++;
      end while (rdy !== 1'b1 && k < 100);
      rv <= 1'b0;
      clr <= 1'b0;
      m = 0;
      do begin
         @(negedge core_clk);
         m++;
         if (refresh_active === 1'b1) check("refresh_in_access", 0, 1);
         if (req_done !== 1'b1) @(posedge core_clk);
      end while (req_done !== 1'b1 && m < 40);
      check("length", 64'(len), 64'(m));
      check("strobes", 64'(ec), 64'(low_cnt));
   endtask

   task automatic summarize;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #200000;
      miscompares++;
      summarize;
   end

   initial begin
      {rst_n, wr, nd, rv, rio, rwr} = '0;
      {wd, ra} = '0;
      clr = 1'b1;
      r = 32'h4f2c;
      bus_timing_control = 32'hFFFFFFFF;
      {compares, miscompares} = '0;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      @(negedge core_clk);
      check("parity_off", 64'h0F, 64'(space_parity_off));
      check("page_size", 64'h07, 64'(dram_page_size));
      run(1'b0, 1'b1, 1'b1, 32'hC0000000);
      for (int i = 0; i < 20; i++) begin
         r = lfsr_next(r);
         set_bcr(r | 32'h00003080);
      end
      $display("test register writes done");
      for (int i = 0; i < 60; i++) begin
         r = lfsr_next(r);
         a = '0;
         a[10:3] = (i < 2) ? {8{i[0]}} : r[10:3];
         run(1'b1, r[12], r[13], a);
      end
      $display("test io accesses done");
      for (int i = 0; i < 100; i++) begin
         r = lfsr_next(r);
         if (i == 0) set_bcr(32'hFFFFFFFF);
         else if (i == 50) set_bcr(32'h00003080);
         else if (i % 10 == 0) set_bcr(r | 32'h00003080);
         r = lfsr_next(r);
         run(1'b0, r[3], r[5], r);
      end
      $display("test memory accesses done");
      for (int c = 0; c < 3; c++) begin
         d = bus_timing_control;
         d[13:12] = 2'(c);
         set_bcr(d);
         repeat ((3 * 512 >> c) + 10) @(posedge core_clk);
         check("refresh_period", 64'(512 >> c), 64'(rf_last - rf_prev));
         check("refresh_len", 64'h04, 64'(rf_len));
      end
      $display("test refresh rates done");
      for (int i = 0; i < 40; i++) begin
         r = lfsr_next(r);
         run(1'b0, r[7], r[9], r);
      end
      d = bus_timing_control;
      d[13:12] = 2'h3;
      set_bcr(d);
      k_off: begin
         int last_seen;
         // a refresh already due at the write may still start
         repeat (10) @(posedge core_clk);
         last_seen = rf_last;
         repeat (600) @(posedge core_clk);
         check("refresh_off", 64'(last_seen), 64'(rf_last));
      end
      $display("test refresh under traffic done");
      summarize;
   end
endmodule // tb
